/* File: dv/plp_checker_sva.sv */
// link checker: frame shape, answer timing, timeout order
// assumes one mclk domain; inputs are the link interface signals
`timescale 1ns/1ps
`default_nettype none
module plp_checker (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        rq_valid,
  input wire logic [31:0] rq_data,
  input wire logic        ac_valid,
  input wire logic [31:0] ac_data
);
  // ----------------
  // word counters
  // ----------------
  logic [2:0]  rq_idx, next_rq_idx, ac_idx, next_ac_idx;
  logic [31:0] rq_tov, next_rq_tov;
  always_comb begin
    next_rq_idx = rq_valid ? rq_idx + 3'h1 : rq_idx;
    next_ac_idx = ac_valid ? ac_idx + 3'h1 : ac_idx;
    next_rq_tov = (rq_valid && rq_idx == 3'h3) ? rq_data : rq_tov;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rq_idx <= 3'h0;
      ac_idx <= 3'h0;
      rq_tov <= 32'h0;
    end else begin
      rq_idx <= next_rq_idx;
      ac_idx <= next_ac_idx;
      rq_tov <= next_rq_tov;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_RQ_RUN: assert property ($rose(rq_valid) |-> rq_valid[*8] ##1 !rq_valid)
    else $error("request frame not eight words");
  AST_AC_RUN: assert property ($rose(ac_valid) |-> ac_valid[*8] ##1 !ac_valid)
    else $error("accept frame not eight words");
  AST_AC_LAT: assert property ((rq_valid && rq_idx == 3'h7) |-> !ac_valid[*2] ##1 ac_valid)
    else $error("accept not two edges after last word");
  AST_NO_OVERLAP: assert property (ac_valid |-> !rq_valid)
    else $error("request word during accept");
  AST_RQ_QUIET: assert property ($fell(rq_valid) |-> !rq_valid[*8])
    else $error("request restarted before accept");
  AST_ACC_EDTOV: assert property ((ac_valid && ac_idx == 3'h3) |-> ac_data >= rq_tov)
    else $error("accept timeout below request");
  AST_RQ_IDX: assert property ($fell(rq_valid) |-> rq_idx == 3'h0)
    else $error("request frame misaligned");
  AST_AC_SRC: assert property ($rose(ac_valid) |-> $past(rq_valid, 2))
    else $error("accept without request");
  cover property (ac_valid && ac_idx == 3'h3 && ac_data > rq_tov);
  cover property ($fell(ac_valid));
  cover property ($rose(rq_valid));
endmodule
`default_nettype wire

/* File: dv/port_login_param_codec_bench.sv */
// bench: originator and responder joined by the link interface
// assumes plp_pkg, plp_link_if and both ends are compiled first
`timescale 1ns/1ps
`default_nettype none
module port_login_param_codec_bench import plp_pkg::*;;
  logic        mclk, resetn, start, ptp, fab, o_busy, o_done, o_err, o_ns;
  logic        r_done, r_err, r_ns, r_prio, r_sync;
  logic [2:0]  cls;
  logic [8:0]  r_pay;
  logic [14:0] r_ee;
  logic [15:0] o_rx, r_rx;
  logic [31:0] cmn2, o_tov, r_tov, o_ag, r_ag;
  logic [32:0] o_ra, r_ra;
  plp_cmn_w0_t cmn0;
  plp_cmn_w1_t o_cmn1, r_cmn1;
  plp_cls_w0_t cls0;
  plp_cls_w1_t cls1;
  plp_cls_w2_t cls2;
  plp_cls_w3_t cls3;
  int          miscompares, total_checks;
  plp_link_if link ();
  plp_orig plp_orig_i (.mclk(mclk), .resetn(resetn), .link(link), .start(start),
    .own_cmn0(cmn0), .own_cmn1(o_cmn1), .own_cmn2(cmn2), .own_edtov(o_tov),
    .own_cls0(cls0), .own_cls1(cls1), .own_cls2(cls2), .own_cls3(cls3),
    .ptp_topology(ptp), .busy(o_busy), .login_done(o_done), .params_err(o_err),
    .edtov_res_ns(o_ns), .agreed_edtov(o_ag), .ratov(o_ra), .peer_rx_size(o_rx));
  plp_resp plp_resp_i (.mclk(mclk), .resetn(resetn), .link(link),
    .own_cmn0(cmn0), .own_cmn1(r_cmn1), .own_cmn2(cmn2), .own_edtov(r_tov),
    .own_cls0(cls0), .own_cls1(cls1), .own_cls2(cls2), .own_cls3(cls3),
    .ptp_topology(ptp), .fabric_login(fab), .login_class(cls), .login_done(r_done),
    .params_err(r_err), .edtov_res_ns(r_ns), .agreed_edtov(r_ag), .ratov(r_ra),
    .peer_payload_bytes(r_pay), .peer_rx_size(r_rx), .peer_ee_credit(r_ee),
    .peer_prio(r_prio), .peer_clk_sync(r_sync));
  plp_checker plp_checker_i (.mclk(mclk), .resetn(resetn), .rq_valid(link.rq_valid),
    .rq_data(link.rq_data), .ac_valid(link.ac_valid), .ac_data(link.ac_data));
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic login();
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(negedge mclk);
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    chk("o_busy", 33'h1, o_busy);
    while (o_done !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
      if (r_done === 1'b1) seen = 1'b1;
    end
    chk("done_wait", 33'h0, {32'h0, n >= 100});
    chk("r_done", 33'h1, {32'h0, seen});
    chk("o_busy_end", 33'h0, o_busy);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_timeout();
    o_tov = 32'h64;
    r_tov = 32'h32;
    r_cmn1.edtov_res_ns = 1'b1;
    login();
    chk("o_agreed", 33'h64, o_ag);
    chk("r_agreed", 33'h64, r_ag);
    chk("o_ratov", 33'hC8, o_ra);
    chk("r_ratov", 33'hC8, r_ra);
    chk("o_res", 33'h1, o_ns);
    chk("r_res", 33'h1, r_ns);
    r_tov = 32'h12C;
    login();
    chk("o_agreed_up", 33'h12C, o_ag);
    ptp = 1'b0;
    r_tov = 32'h2BC;
    login();
    chk("o_agreed_keep", 33'h12C, o_ag);
    ptp = 1'b1;
  endtask
  task automatic t_rxsize();
    logic [15:0] v [5] = '{16'h00FC, 16'h0102, 16'h0844, 16'h0100, 16'h0840};
    for (int i = 0; i < 5; i++) begin
      o_cmn1.rx_size = v[i];
      o_cmn1.payload_256 = i[0];
      login();
      chk("r_err_rx", {32'h0, i < 3}, r_err);
      chk("r_rx", {17'h0, v[i]}, r_rx);
      chk("r_payload", i[0] ? 33'h100 : 33'h080, r_pay);
    end
    r_cmn1.rx_size = 16'h0080;
    login();
    chk("o_err_rx", 33'h1, o_err);
    chk("o_rx", 33'h080, o_rx);
    r_cmn1.rx_size = 16'h0800;
  endtask
  task automatic t_version();
    logic [7:0] v [6] = '{8'h09, 8'h0A, 8'h10, 8'h15, 8'h20, 8'h21};
    for (int i = 0; i < 6; i++) begin
      cmn0.ver_high = v[i];
      login();
      chk("r_err_ver", {32'h0, i[0]}, r_err);
    end
    cmn0.ver_high = 8'h20;
  endtask
  task automatic t_class();
    logic [2:0] c [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    for (int i = 0; i < 6; i++) begin
      cls = (i < 5) ? c[i] : 3'h1;
      fab = (i == 5);
      login();
      chk("r_prio", {32'h0, cls != 3'h3}, r_prio);
      chk("r_ee", (i < 5 && cls != 3'h3 && cls != 3'h4) ? 33'h123 : 33'h0, r_ee);
      chk("r_sync", 33'h1, r_sync);
    end
    fab = 1'b0;
  endtask
  // ----------------
  // run control
  // ----------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    {resetn, start, fab, cmn2, o_tov, r_tov, cls2, cls3} = '0;
    {ptp, cls} = 4'h9;
    cmn0 = {8'h20, 8'h10, 16'h0};
    // reserved common bits set on purpose: the responder must not flag them
    o_cmn1 = 32'h03BE_0800;
    r_cmn1 = 32'h0000_0800;
    cls0 = '0;
    cls0.prio = 1'b1;
    cls0.clk_sync = 1'b1;
    cls1 = '0;
    cls1.clk_sync = 1'b1;
    cls1.rx_size = 16'h0800;
    cls2.ee_credit = 15'h0123;
    repeat (20) @(negedge mclk);
    chk("rst_payload", 33'h080, r_pay);
    resetn = 1'b1;
    t_timeout();
    t_rxsize();
    t_version();
    t_class();
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: verilog/plp_link_if.sv */
// word link between the login originator and the responding port
// assumes both ends share mclk; words move one per valid cycle, no stall
`timescale 1ns/1ps
`default_nettype none
interface plp_link_if;
  logic        rq_valid;
  logic [31:0] rq_data;
  logic        ac_valid;
  logic [31:0] ac_data;

  modport orig (output rq_valid, output rq_data, input ac_valid, input ac_data);
  modport resp (input rq_valid, input rq_data, output ac_valid, output ac_data);
endinterface
`default_nettype wire

/* File: verilog/plp_orig.sv */
// originating port: sends a login request and adopts the accept reply
// assumes the responder answers with eight words on the same mclk
`timescale 1ns/1ps
`default_nettype none
module plp_orig
  import plp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  plp_link_if.orig         link,
  input  wire logic        start,
  input  wire plp_cmn_w0_t own_cmn0,
  input  wire plp_cmn_w1_t own_cmn1,
  input  wire logic [31:0] own_cmn2,
  input  wire logic [31:0] own_edtov,
  input  wire plp_cls_w0_t own_cls0,
  input  wire plp_cls_w1_t own_cls1,
  input  wire plp_cls_w2_t own_cls2,
  input  wire plp_cls_w3_t own_cls3,
  input  wire logic        ptp_topology,
  output logic             busy,
  output logic             login_done,
  output logic             params_err,
  output logic             edtov_res_ns,
  output logic [31:0]      agreed_edtov,
  output logic [32:0]      ratov,
  output logic [15:0]      peer_rx_size
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  plp_state_t           state;
  plp_state_t           next_state;
  logic [PLP_IDX_W-1:0] idx;
  logic [PLP_IDX_W-1:0] next_idx;
  logic [31:0]          req_edtov;
  logic [31:0]          next_req_edtov;
  logic [31:0]          acc_edtov;
  logic [31:0]          next_acc_edtov;
  plp_cmn_w1_t          acc_cmn1;
  plp_cmn_w1_t          next_acc_cmn1;
  logic                 rq_valid;
  logic                 next_rq_valid;
  logic [31:0]          rq_data;
  logic [31:0]          next_rq_data;
  logic                 next_login_done;
  logic                 next_params_err;
  logic                 next_edtov_res_ns;
  logic [31:0]          next_agreed_edtov;
  logic [32:0]          next_ratov;
  logic [15:0]          next_peer_rx_size;
  logic [31:0]          req_word;

  assign link.rq_valid = rq_valid;
  assign link.rq_data  = rq_data;
  assign busy          = (state != PLP_ST_IDLE);

  always_comb begin
    case (idx)
      PLP_IDX_CMN0: req_word = own_cmn0;
      PLP_IDX_CMN1: req_word = own_cmn1;
      PLP_IDX_CMN2: req_word = own_cmn2;
      PLP_IDX_CMN3: req_word = ptp_topology ? own_edtov : 32'h0000_0000;
      PLP_IDX_CLS0: req_word = own_cls0;
      PLP_IDX_CLS1: req_word = own_cls1;
      PLP_IDX_CLS2: req_word = own_cls2;
      default:      req_word = own_cls3;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_state        = state;
    next_idx          = idx;
    next_req_edtov    = req_edtov;
    next_acc_edtov    = acc_edtov;
    next_acc_cmn1     = acc_cmn1;
    next_rq_valid     = 1'b0;
    next_rq_data      = rq_data;
    next_login_done   = 1'b0;
    next_params_err   = params_err;
    next_edtov_res_ns = edtov_res_ns;
    next_agreed_edtov = agreed_edtov;
    next_ratov        = ratov;
    next_peer_rx_size = peer_rx_size;
    case (state)
      PLP_ST_IDLE: begin
        if (start) begin
          next_state     = PLP_ST_SEND;
          next_idx       = PLP_IDX_CMN0;
          next_req_edtov = own_edtov;
        end
      end
      PLP_ST_SEND: begin
        next_rq_valid = 1'b1;
        next_rq_data  = req_word;
        next_idx      = idx + 1'b1;
        if (idx == PLP_IDX_CLS3) begin
          next_state = PLP_ST_WAIT;
          next_idx   = PLP_IDX_CMN0;
        end
      end
      PLP_ST_WAIT: begin
        if (link.ac_valid) begin
          next_idx = idx + 1'b1;
          if (idx == PLP_IDX_CMN1) begin
            next_acc_cmn1 = plp_cmn_w1_t'(link.ac_data);
          end
          if (idx == PLP_IDX_CMN3) begin
            next_acc_edtov = link.ac_data;
          end
          if (idx == PLP_IDX_CLS3) begin
            next_state        = PLP_ST_IDLE;
            next_idx          = PLP_IDX_CMN0;
            next_login_done   = 1'b1;
            next_params_err   = !plp_rx_ok(acc_cmn1.rx_size)
                                || (ptp_topology && (acc_edtov < req_edtov));
            next_edtov_res_ns = acc_cmn1.edtov_res_ns;
            next_agreed_edtov = ptp_topology ? acc_edtov : agreed_edtov;
            next_ratov        = ptp_topology ? {acc_edtov, 1'b0} : ratov;
            next_peer_rx_size = acc_cmn1.rx_size;
          end
        end
      end
      default: begin
        next_state = PLP_ST_IDLE;
        next_idx   = PLP_IDX_CMN0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state        <= PLP_ST_IDLE;
      idx          <= PLP_IDX_CMN0;
      req_edtov    <= 32'h0000_0000;
      acc_edtov    <= 32'h0000_0000;
      acc_cmn1     <= '0;
      rq_valid     <= 1'b0;
      rq_data      <= 32'h0000_0000;
      login_done   <= 1'b0;
      params_err   <= 1'b0;
      edtov_res_ns <= PLP_RES_MS;
      agreed_edtov <= 32'h0000_0000;
      ratov        <= 33'h0_0000_0000;
      peer_rx_size <= 16'h0000;
    end else begin
      state        <= next_state;
      idx          <= next_idx;
      req_edtov    <= next_req_edtov;
      acc_edtov    <= next_acc_edtov;
      acc_cmn1     <= next_acc_cmn1;
      rq_valid     <= next_rq_valid;
      rq_data      <= next_rq_data;
      login_done   <= next_login_done;
      params_err   <= next_params_err;
      edtov_res_ns <= next_edtov_res_ns;
      agreed_edtov <= next_agreed_edtov;
      ratov        <= next_ratov;
      peer_rx_size <= next_peer_rx_size;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/plp_pkg.sv */
// login service parameter layouts, limits and codes shared by both ends
// assumes both ends run on one mclk and exchange eight-word payload bodies
package plp_pkg;

  // ------------------------------------------------------------
  // frame layout: four common words, then four class words
  // ------------------------------------------------------------
  localparam int unsigned PLP_WORDS    = 8;
  localparam int unsigned PLP_IDX_W    = 3;
  localparam logic [2:0]  PLP_IDX_CMN0 = 3'h0;
  localparam logic [2:0]  PLP_IDX_CMN1 = 3'h1;
  localparam logic [2:0]  PLP_IDX_CMN2 = 3'h2;
  localparam logic [2:0]  PLP_IDX_CMN3 = 3'h3;
  localparam logic [2:0]  PLP_IDX_CLS0 = 3'h4;
  localparam logic [2:0]  PLP_IDX_CLS1 = 3'h5;
  localparam logic [2:0]  PLP_IDX_CLS2 = 3'h6;
  localparam logic [2:0]  PLP_IDX_CLS3 = 3'h7;

  // ------------------------------------------------------------
  // limits and codes
  // ------------------------------------------------------------
  localparam logic [15:0] PLP_RX_MIN       = 16'h0100;
  localparam logic [15:0] PLP_RX_MAX       = 16'h0840;
  localparam logic [1:0]  PLP_RX_ALIGN     = 2'h0;
  localparam logic [7:0]  PLP_VER_OLD_MAX  = 8'h09;
  localparam logic [7:0]  PLP_VER_REV2     = 8'h10;
  localparam logic [7:0]  PLP_VER_REV3     = 8'h20;
  localparam logic [8:0]  PLP_PAYLOAD_128  = 9'h080;
  localparam logic [8:0]  PLP_PAYLOAD_256  = 9'h100;
  localparam logic        PLP_RES_MS       = 1'b0;
  localparam logic [2:0]  PLP_CLASS_1      = 3'h1;
  localparam logic [2:0]  PLP_CLASS_2      = 3'h2;
  localparam logic [2:0]  PLP_CLASS_3      = 3'h3;
  localparam logic [2:0]  PLP_CLASS_6      = 3'h6;

  // ------------------------------------------------------------
  // word layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ver_high;
    logic [7:0]  ver_low;
    logic [15:0] bb_credit;
  } plp_cmn_w0_t;

  typedef struct packed {
    logic        cont_incr;
    logic        rand_offset;
    logic        vendor_ver;
    logic        nport_fport;
    logic        alt_bb_credit;
    logic        edtov_res_ns;
    logic [2:0]  rsvd_25_23;
    logic        feat_22;
    logic [4:0]  rsvd_21_17;
    logic        payload_256;
    logic [15:0] rx_size;
  } plp_cmn_w1_t;

  typedef struct packed {
    logic        valid;
    logic        intermix;
    logic [1:0]  stacked_conn;
    logic        seq_delivery;
    logic        ded_simplex;
    logic        camp_on;
    logic        buffered_c1;
    logic        prio;
    logic [6:0]  rsvd_22_16;
    logic [1:0]  xid_reassign;
    logic [1:0]  init_assoc;
    logic        ack0;
    logic        ackn;
    logic        ack_assist;
    logic        compress;
    logic [1:0]  history;
    logic        encrypt;
    logic        clk_sync;
    logic [3:0]  rsvd_3_0;
  } plp_cls_w0_t;

  typedef struct packed {
    logic        ack0;
    logic        ackn;
    logic        xid_interlock;
    logic [1:0]  err_policy;
    logic        rsvd_26;
    logic [1:0]  cat_per_seq;
    logic        compress;
    logic [1:0]  history;
    logic        decrypt;
    logic        clk_sync;
    logic [2:0]  fabric_rsvd;
    logic [15:0] rx_size;
  } plp_cls_w1_t;

  typedef struct packed {
    logic [15:0] concur_seq;
    logic        rsvd_15;
    logic [14:0] ee_credit;
  } plp_cls_w2_t;

  typedef struct packed {
    logic [15:0] open_seq;
    logic [15:0] mcast_rxid;
  } plp_cls_w3_t;

  typedef enum logic [1:0] {
    PLP_ST_IDLE = 2'b00,
    PLP_ST_SEND = 2'b01,
    PLP_ST_WAIT = 2'b10
  } plp_state_t;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  function automatic logic plp_rx_ok(input logic [15:0] size);
    plp_rx_ok = (size >= PLP_RX_MIN) && (size <= PLP_RX_MAX)
                && (size[1:0] == PLP_RX_ALIGN);
  endfunction

  function automatic logic plp_ver_ok(input logic [7:0] ver);
    plp_ver_ok = (ver <= PLP_VER_OLD_MAX) || (ver == PLP_VER_REV2)
                 || (ver == PLP_VER_REV3);
  endfunction

endpackage

/* File: verilog/plp_resp.sv */
// responding port: takes a login request, checks it, answers with an accept
// assumes request words arrive in order on mclk, eight per request
`timescale 1ns/1ps
`default_nettype none

module plp_resp
  import plp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  plp_link_if.resp         link,
  input  wire plp_cmn_w0_t own_cmn0,
  input  wire plp_cmn_w1_t own_cmn1,
  input  wire logic [31:0] own_cmn2,
  input  wire logic [31:0] own_edtov,
  input  wire plp_cls_w0_t own_cls0,
  input  wire plp_cls_w1_t own_cls1,
  input  wire plp_cls_w2_t own_cls2,
  input  wire plp_cls_w3_t own_cls3,
  input  wire logic        ptp_topology,
  input  wire logic        fabric_login,
  input  wire logic [2:0]  login_class,
  output logic             login_done,
  output logic             params_err,
  output logic             edtov_res_ns,
  output logic [31:0]      agreed_edtov,
  output logic [32:0]      ratov,
  output logic [8:0]       peer_payload_bytes,
  output logic [15:0]      peer_rx_size,
  output logic [14:0]      peer_ee_credit,
  output logic             peer_prio,
  output logic             peer_clk_sync
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  plp_state_t             state;
  plp_state_t             next_state;
  logic [PLP_IDX_W-1:0]   idx;
  logic [PLP_IDX_W-1:0]   next_idx;
  logic [31:0]            rx_w [PLP_WORDS];
  logic [31:0]            next_rx_w [PLP_WORDS];
  logic [31:0]            acc_edtov;
  logic [31:0]            next_acc_edtov;
  logic                   ac_valid;
  logic                   next_ac_valid;
  logic [31:0]            ac_data;
  logic [31:0]            next_ac_data;
  logic                   next_login_done;
  logic                   next_params_err;
  logic                   next_edtov_res_ns;
  logic [31:0]            next_agreed_edtov;
  logic [32:0]            next_ratov;
  logic [8:0]             next_peer_payload_bytes;
  logic [15:0]            next_peer_rx_size;
  logic [14:0]            next_peer_ee_credit;
  logic                   next_peer_prio;
  logic                   next_peer_clk_sync;

  // ------------------------------------------------------------
  // views of the stored request
  // ------------------------------------------------------------
  plp_cmn_w0_t rq_cmn0;
  plp_cmn_w1_t rq_cmn1;
  plp_cls_w0_t rq_cls0;
  plp_cls_w1_t rq_cls1;
  plp_cls_w2_t rq_cls2;
  logic        rq_bad;
  logic        rq_last;
  logic        credit_class;

  assign rq_cmn0 = plp_cmn_w0_t'(rx_w[PLP_IDX_CMN0]);
  assign rq_cmn1 = plp_cmn_w1_t'(rx_w[PLP_IDX_CMN1]);
  assign rq_cls0 = plp_cls_w0_t'(rx_w[PLP_IDX_CLS0]);
  assign rq_cls1 = plp_cls_w1_t'(rx_w[PLP_IDX_CLS1]);
  assign rq_cls2 = plp_cls_w2_t'(rx_w[PLP_IDX_CLS2]);
  assign rq_last = link.rq_valid && (idx == PLP_IDX_CLS3);
  assign credit_class = (login_class == PLP_CLASS_1) || (login_class == PLP_CLASS_2)
                        || (login_class == PLP_CLASS_6);

  // class receive size is not meaningful in fabric login, so only checked otherwise
  assign rq_bad = !plp_rx_ok(rq_cmn1.rx_size)
                  || (!fabric_login && !plp_rx_ok(rq_cls1.rx_size))
                  || !plp_ver_ok(rq_cmn0.ver_high)
                  || !plp_ver_ok(rq_cmn0.ver_low);

  assign link.ac_valid = ac_valid;
  assign link.ac_data  = ac_data;

  // ------------------------------------------------------------
  // accept word builder
  // ------------------------------------------------------------
  function automatic logic [31:0] acc_word(input logic [PLP_IDX_W-1:0] i);
    case (i)
      PLP_IDX_CMN0: acc_word = own_cmn0;
      PLP_IDX_CMN1: acc_word = own_cmn1;
      PLP_IDX_CMN2: acc_word = own_cmn2;
      PLP_IDX_CMN3: acc_word = ptp_topology ? acc_edtov : 32'h0000_0000;
      PLP_IDX_CLS0: acc_word = own_cls0;
      PLP_IDX_CLS1: acc_word = own_cls1;
      PLP_IDX_CLS2: acc_word = own_cls2;
      default:      acc_word = own_cls3;
    endcase
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_state              = state;
    next_idx                = idx;
    next_rx_w               = rx_w;
    next_acc_edtov          = acc_edtov;
    next_ac_valid           = 1'b0;
    next_ac_data            = ac_data;
    next_login_done         = 1'b0;
    next_params_err         = params_err;
    next_edtov_res_ns       = edtov_res_ns;
    next_agreed_edtov       = agreed_edtov;
    next_ratov              = ratov;
    next_peer_payload_bytes = peer_payload_bytes;
    next_peer_rx_size       = peer_rx_size;
    next_peer_ee_credit     = peer_ee_credit;
    next_peer_prio          = peer_prio;
    next_peer_clk_sync      = peer_clk_sync;
    case (state)
      PLP_ST_IDLE: begin
        // words of a new request during an accept are dropped: no back-pressure
        if (link.rq_valid) begin
          next_rx_w[idx] = link.rq_data;
          next_idx       = idx + 1'b1;
          if (rq_last) begin
            next_state = PLP_ST_SEND;
            next_idx   = PLP_IDX_CMN0;
            // in point-to-point topology a larger request value is adopted so the accept never shrinks it
            if (ptp_topology && (rx_w[PLP_IDX_CMN3] > own_edtov)) begin
              next_acc_edtov = rx_w[PLP_IDX_CMN3];
            end else begin
              next_acc_edtov = own_edtov;
            end
            next_params_err         = rq_bad;
            next_peer_payload_bytes = rq_cmn1.payload_256 ? PLP_PAYLOAD_256
                                                          : PLP_PAYLOAD_128;
            next_peer_rx_size       = rq_cmn1.rx_size;
            next_peer_prio          = rq_cls0.prio && (login_class != PLP_CLASS_3);
            next_peer_clk_sync      = rq_cls0.clk_sync;
            next_peer_ee_credit     = (credit_class && !fabric_login)
                                      ? rq_cls2.ee_credit : 15'h0000;
          end
        end
      end
      PLP_ST_SEND: begin
        next_ac_valid = 1'b1;
        next_ac_data  = acc_word(idx);
        next_idx      = idx + 1'b1;
        if (idx == PLP_IDX_CLS3) begin
          next_state        = PLP_ST_IDLE;
          next_idx          = PLP_IDX_CMN0;
          next_login_done   = 1'b1;
          next_edtov_res_ns = own_cmn1.edtov_res_ns;
          next_agreed_edtov = acc_edtov;
          next_ratov        = ptp_topology ? {acc_edtov, 1'b0} : ratov;
        end
      end
      default: begin
        next_state = PLP_ST_IDLE;
        next_idx   = PLP_IDX_CMN0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state              <= PLP_ST_IDLE;
      idx                <= PLP_IDX_CMN0;
      acc_edtov          <= 32'h0000_0000;
      ac_valid           <= 1'b0;
      ac_data            <= 32'h0000_0000;
      login_done         <= 1'b0;
      params_err         <= 1'b0;
      edtov_res_ns       <= PLP_RES_MS;
      agreed_edtov       <= 32'h0000_0000;
      ratov              <= 33'h0_0000_0000;
      peer_payload_bytes <= PLP_PAYLOAD_128;
      peer_rx_size       <= 16'h0000;
      peer_ee_credit     <= 15'h0000;
      peer_prio          <= 1'b0;
      peer_clk_sync      <= 1'b0;
    end else begin
      state              <= next_state;
      idx                <= next_idx;
      acc_edtov          <= next_acc_edtov;
      ac_valid           <= next_ac_valid;
      ac_data            <= next_ac_data;
      login_done         <= next_login_done;
      params_err         <= next_params_err;
      edtov_res_ns       <= next_edtov_res_ns;
      agreed_edtov       <= next_agreed_edtov;
      ratov              <= next_ratov;
      peer_payload_bytes <= next_peer_payload_bytes;
      peer_rx_size       <= next_peer_rx_size;
      peer_ee_credit     <= next_peer_ee_credit;
      peer_prio          <= next_peer_prio;
      peer_clk_sync      <= next_peer_clk_sync;
    end
  end

  // ------------------------------------------------------------
  // request word store
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PLP_WORDS; g++) begin : g_store
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          rx_w[g] <= 32'h0000_0000;
        end else begin
          rx_w[g] <= next_rx_w[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire
